/* logic/reader_host_command_port.sv */
// Purpose: host command port of a contactless reader front end (slave only)
// Assumes: DATA_CLK and pins are asynchronous and far slower than SYS_CLK
// Notes: register writes leave through a FIFO, reads are fetched on demand
//
// Function
// R1: one host link active: parallel bus or serial link, never both.
// R2: straps sampled at power-up; unequal levels select serial, equal select parallel.
// R3: board ties straps 110 for serial with select, 100 without.
// R4: device is slave only; host starts every transfer.
// R5: interrupt request output asks host for service in every mode.
// R6: serial input on line seven, output on line six, master clock.
// R7: serial mode with select uses line four as active-low select.
// R8: parallel direct mode drives raw stream on six, strobe on five.
// R9: line five high during the eight read data clocks after address.
// R10: first byte after start is the address/command word.
// R11: word bit seven: zero register address, one direct command.
// R12: address word bit six: one read, zero write.
// R13: bits four to zero carry register address or command code.
// R14: bit five set: address advances by one per further byte.
// R15: bit five clear: one data byte per address word, pairs repeat.
// R16: data bytes follow the address word; reach registers and FIFO.
// R17: host sets auto-increment when loading over twelve FIFO bytes.
// R18: a command word triggers a reader action.
// R19: command transaction: start, command word, optional bytes, stop.
// R20: command code 0x0f is the reset command.
// R21: parallel start: line seven rises while clock high; resets interface.
// R22: parallel simple stop: line seven falls while clock high; ends direct.
// R23: serial bytes shift msb first, one bit per clock, on byte boundaries.
// R24: host holds select low for a whole transaction, high ends it.

`timescale 1ns/1ps

// =============================================================
// write buffer between link and register side
module write_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push, pop;

    // full and empty come from the stored count, never from pointer guesses
    assign in_ready = (count_reg != FULL_COUNT);
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PW'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (PW+1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (PW+1)'(1);
            end
        end
    end
endmodule // write_fifo

// =============================================================
// top: link slave, word decode, read fetch, command strobes
module reader_host_command_port (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic DATA_CLK,
    input wire logic [7:0] IO_IN,
    output logic [7:0] IO_OUT,
    output logic [7:0] IO_OE,
    output logic IRQ,
    input wire logic IRQ_REQ,
    output logic [1:0] MODE,
    output logic MODE_VALID,
    output logic WR_VALID,
    input wire logic WR_READY,
    output logic [4:0] WR_ADDR,
    output logic [7:0] WR_DATA,
    output logic WR_OVERFLOW,
    output logic RD_STROBE,
    output logic [4:0] RD_ADDR,
    input wire logic [7:0] RD_DATA,
    output logic CMD_STROBE,
    output logic [4:0] CMD_CODE,
    output logic RESET_CMD,
    input wire logic DIRECT_EN,
    input wire logic DIRECT_DATA,
    input wire logic DIRECT_STROBE,
    output logic DIRECT_END
);
    // =========================================================
    // declarations
    logic clk_s1_reg, clk_s2_reg, clk_prev_reg;
    logic [7:0] io_s1_reg, io_s2_reg;
    logic [2:0] strap_s1_reg, strap_s2_reg;
    logic mosi_prev_reg, ss_prev_reg;
    logic [1:0] strap_cnt_reg;
    reader_port_pkg::mode_t mode_reg;
    logic mode_valid_reg;
    reader_port_pkg::xfer_state_t state_reg;
    logic [4:0] addr_reg;
    logic rd_reg, cont_reg;
    logic [2:0] bitcnt_reg;
    logic [6:0] rx_shift_reg;
    logic [7:0] tx_shift_reg;
    logic cont_armed_reg, rd_wait_reg;
    logic [7:0] io_out_reg, io_oe_reg;
    logic irq_reg, rd_strobe_reg, cmd_strobe_reg, reset_cmd_reg, direct_end_reg, ovf_reg;
    logic [4:0] rd_addr_reg, cmd_code_reg;
    logic clk_rise, clk_fall, serial, mosi_rise, mosi_fall, ss_fall, ss_rise;
    logic start_evt, stop_evt, simple_stop, cont_stop, byte_done;
    logic [7:0] byte_now;
    logic is_cmd_word, rd_req, push_valid, push_ready, rd_phase, cmd_take;
    logic [4:0] rd_addr_next;
    logic [12:0] fifo_out;

    // =========================================================
    // two-flop synchronisers on every pin; prev flops look at stage two only
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_prev_reg <= 1'b0;
            io_s1_reg <= 8'h00;
            io_s2_reg <= 8'h00;
            strap_s1_reg <= 3'h0;
            strap_s2_reg <= 3'h0;
            mosi_prev_reg <= 1'b0;
            ss_prev_reg <= 1'b1;
        end else begin
            clk_s1_reg <= DATA_CLK;
            clk_s2_reg <= clk_s1_reg;
            clk_prev_reg <= clk_s2_reg;
            io_s1_reg <= IO_IN;
            io_s2_reg <= io_s1_reg;
            strap_s1_reg <= IO_IN[2:0];
            strap_s2_reg <= strap_s1_reg;
            mosi_prev_reg <= io_s2_reg[reader_port_pkg::LINE_MOSI];
            ss_prev_reg <= io_s2_reg[reader_port_pkg::LINE_SS];
        end
    end

    // edges of the master clock and of the control lines
    assign clk_rise = clk_s2_reg && !clk_prev_reg;
    assign clk_fall = !clk_s2_reg && clk_prev_reg;
    assign mosi_rise = io_s2_reg[reader_port_pkg::LINE_MOSI] && !mosi_prev_reg;
    assign mosi_fall = !io_s2_reg[reader_port_pkg::LINE_MOSI] && mosi_prev_reg;
    assign ss_fall = !io_s2_reg[reader_port_pkg::LINE_SS] && ss_prev_reg;
    assign ss_rise = io_s2_reg[reader_port_pkg::LINE_SS] && !ss_prev_reg;
    assign serial = (mode_reg != reader_port_pkg::MODE_PARALLEL);

    // =========================================================
    // strap capture once the synchronisers hold real pin levels
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            strap_cnt_reg <= 2'h0;
            mode_reg <= reader_port_pkg::MODE_PARALLEL;
            mode_valid_reg <= 1'b0;
        end else if (strap_cnt_reg != reader_port_pkg::STRAP_SETTLE) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == reader_port_pkg::STRAP_TAKE) begin
                mode_valid_reg <= 1'b1;
                // mode is frozen: only one link is ever active (see R1)
                if (strap_s2_reg == 3'h0 || strap_s2_reg == 3'h7) begin
                    mode_reg <= reader_port_pkg::MODE_PARALLEL; // see R2
                end else if (strap_s2_reg[reader_port_pkg::STRAP_ONE]) begin
                    mode_reg <= reader_port_pkg::MODE_SPI_SS; // see R2, see R3
                end else begin
                    mode_reg <= reader_port_pkg::MODE_SPI_NOSS; // see R2, see R3
                end
            end
        end
    end

    // =========================================================
    // start and stop conditions; the host alone opens a frame (see R4)
    assign simple_stop = mosi_fall && clk_s2_reg; // see R22
    assign cont_stop = !serial && mosi_fall && !clk_s2_reg && cont_armed_reg;
    always_comb begin
        if (!mode_valid_reg) begin
            start_evt = 1'b0;
            stop_evt = 1'b0;
        end else if (mode_reg == reader_port_pkg::MODE_SPI_SS) begin
            start_evt = ss_fall; // see R7, see R24
            stop_evt = ss_rise;
        end else begin
            start_evt = mosi_rise && clk_s2_reg; // see R21
            stop_evt = simple_stop || cont_stop;
        end
    end

    // continuous stop needs a rise then a fall of line seven, both with clock low
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            cont_armed_reg <= 1'b0;
        end else if (clk_rise || start_evt || stop_evt) begin
            cont_armed_reg <= 1'b0;
        end else if (mosi_rise && !clk_s2_reg) begin
            cont_armed_reg <= 1'b1;
        end
    end

    // =========================================================
    // byte assembly: serial msb first on line seven, parallel whole bus
    assign byte_now = serial ? {rx_shift_reg, io_s2_reg[reader_port_pkg::LINE_MOSI]}
                             : io_s2_reg; // see R6, see R23
    assign byte_done = clk_rise && !start_evt && (state_reg != reader_port_pkg::ST_IDLE)
                       && (!serial || bitcnt_reg == reader_port_pkg::LAST_BIT);

    // bit counter restarts at every start so bytes sit on eight-clock boundaries
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            bitcnt_reg <= 3'h0;
            rx_shift_reg <= 7'h00;
        end else if (start_evt) begin
            bitcnt_reg <= 3'h0; // see R23
        end else if (clk_rise && state_reg != reader_port_pkg::ST_IDLE) begin
            bitcnt_reg <= bitcnt_reg + 3'h1;
            rx_shift_reg <= byte_now[6:0];
        end
    end

    // =========================================================
    // word decode
    assign is_cmd_word = byte_now[reader_port_pkg::WORD_CMD_BIT]; // see R11
    assign cmd_take = byte_done && is_cmd_word && (state_reg != reader_port_pkg::ST_DATA);
    assign rd_phase = (state_reg == reader_port_pkg::ST_DATA) && rd_reg;
    assign push_valid = byte_done && (state_reg == reader_port_pkg::ST_DATA) && !rd_reg;
    assign rd_addr_next = (state_reg == reader_port_pkg::ST_WORD) ? byte_now[4:0]
                                                                  : addr_reg + 5'h01;
    assign rd_req = byte_done && (((state_reg == reader_port_pkg::ST_WORD) && !is_cmd_word
                    && byte_now[reader_port_pkg::WORD_RD_BIT])
                    || (rd_phase && cont_reg)); // see R12, see R14

    // transaction state; start wins over stop and data
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= reader_port_pkg::ST_IDLE;
            addr_reg <= 5'h00;
            rd_reg <= 1'b0;
            cont_reg <= 1'b0;
        end else if (start_evt) begin
            state_reg <= reader_port_pkg::ST_WORD; // see R10, see R21
        end else if (stop_evt) begin
            state_reg <= reader_port_pkg::ST_IDLE; // see R19, see R22
        end else if (byte_done) begin
            unique case (state_reg)
                reader_port_pkg::ST_WORD: begin
                    if (is_cmd_word) begin
                        state_reg <= reader_port_pkg::ST_CMD; // see R19
                    end else begin
                        addr_reg <= byte_now[4:0]; // see R13
                        rd_reg <= byte_now[reader_port_pkg::WORD_RD_BIT]; // see R12
                        cont_reg <= byte_now[reader_port_pkg::WORD_CONT_BIT];
                        state_reg <= reader_port_pkg::ST_DATA; // see R16
                    end
                end
                reader_port_pkg::ST_DATA: begin
                    if (cont_reg) begin
                        addr_reg <= addr_reg + 5'h01; // see R14
                    end else begin
                        state_reg <= reader_port_pkg::ST_WORD; // see R15
                    end
                end
                reader_port_pkg::ST_CMD: state_reg <= reader_port_pkg::ST_CMD;
                reader_port_pkg::ST_IDLE: state_reg <= reader_port_pkg::ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // command strobes; later command bytes in a command frame also act
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            cmd_strobe_reg <= 1'b0;
            cmd_code_reg <= 5'h00;
            reset_cmd_reg <= 1'b0;
        end else begin
            cmd_strobe_reg <= cmd_take; // see R18
            reset_cmd_reg <= cmd_take && byte_now[4:0] == reader_port_pkg::CMD_RESET; // see R20
            if (cmd_take) begin
                cmd_code_reg <= byte_now[4:0]; // see R13
            end
        end
    end

    // =========================================================
    // read fetch: strobe, data taken one cycle later, long before the next fall
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rd_strobe_reg <= 1'b0;
            rd_addr_reg <= 5'h00;
            rd_wait_reg <= 1'b0;
            tx_shift_reg <= 8'h00;
        end else begin
            rd_strobe_reg <= rd_req;
            rd_wait_reg <= rd_strobe_reg;
            if (rd_req) begin
                rd_addr_reg <= rd_addr_next; // see R14
            end
            if (rd_wait_reg) begin
                tx_shift_reg <= RD_DATA;
            end else if (serial && clk_fall && rd_phase) begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0}; // see R23
            end
        end
    end

    // =========================================================
    // pin drive; serial data changes on the falling clock so the host samples on rise
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            io_out_reg <= 8'h00;
            io_oe_reg <= reader_port_pkg::OE_NONE;
        end else if (serial) begin
            io_oe_reg <= reader_port_pkg::OE_NONE;
            io_oe_reg[reader_port_pkg::LINE_MISO] <= (state_reg != reader_port_pkg::ST_IDLE);
            io_oe_reg[reader_port_pkg::LINE_RDFLAG] <= 1'b1;
            io_out_reg[reader_port_pkg::LINE_RDFLAG] <= rd_phase; // see R9
            if (clk_fall && rd_phase) begin
                io_out_reg[reader_port_pkg::LINE_MISO] <= tx_shift_reg[7]; // see R6
            end
        end else if (DIRECT_EN) begin
            io_oe_reg <= reader_port_pkg::OE_NONE;
            io_oe_reg[reader_port_pkg::LINE_DIRECT] <= 1'b1;
            io_oe_reg[reader_port_pkg::LINE_STROBE] <= 1'b1;
            io_out_reg[reader_port_pkg::LINE_DIRECT] <= DIRECT_DATA; // see R8
            io_out_reg[reader_port_pkg::LINE_STROBE] <= DIRECT_STROBE; // see R8
        end else begin
            // parallel read drives the whole bus through the data phase
            io_oe_reg <= rd_phase ? reader_port_pkg::OE_ALL : reader_port_pkg::OE_NONE;
            io_out_reg <= tx_shift_reg;
        end
    end

    // =========================================================
    // status outputs; overflow set wins over the clear at start
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_reg <= 1'b0;
            direct_end_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            irq_reg <= IRQ_REQ; // see R5
            direct_end_reg <= !serial && mode_valid_reg && DIRECT_EN && simple_stop; // see R22
            if (push_valid && !push_ready) begin
                ovf_reg <= 1'b1;
            end else if (start_evt) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    // the host cannot be paused, so a full buffer drops the byte and flags it
    write_fifo #(
        .WIDTH(reader_port_pkg::FIFO_W),
        .DEPTH(reader_port_pkg::FIFO_DEPTH)
    ) u_write_fifo (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .in_valid(push_valid), // see R16
        .in_ready(push_ready),
        .in_data({addr_reg, byte_now}),
        .out_valid(WR_VALID),
        .out_ready(WR_READY),
        .out_data(fifo_out)
    );

    assign WR_ADDR = fifo_out[12:8];
    assign WR_DATA = fifo_out[7:0];
    assign IO_OUT = io_out_reg;
    assign IO_OE = io_oe_reg;
    assign IRQ = irq_reg;
    assign MODE = mode_reg;
    assign MODE_VALID = mode_valid_reg;
    assign WR_OVERFLOW = ovf_reg;
    assign RD_STROBE = rd_strobe_reg;
    assign RD_ADDR = rd_addr_reg;
    assign CMD_STROBE = cmd_strobe_reg;
    assign CMD_CODE = cmd_code_reg;
    assign RESET_CMD = reset_cmd_reg;
    assign DIRECT_END = direct_end_reg;
endmodule // reader_host_command_port

/* logic/reader_port_pkg.sv */
// Purpose: shared constants and types of the reader host command port
// Assumes: one byte-wide host link, straps on lines two to zero
// Notes: all field positions and codes live here once

package reader_port_pkg;

    // =========================================================
    // interface modes chosen by the straps
    typedef enum logic [1:0] {
        MODE_PARALLEL = 2'b00,
        MODE_SPI_SS   = 2'b01,
        MODE_SPI_NOSS = 2'b10
    } mode_t;

    // =========================================================
    // transaction states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WORD = 2'b01,
        ST_DATA = 2'b10,
        ST_CMD  = 2'b11
    } xfer_state_t;

    // =========================================================
    // address/command word layout
    localparam int WORD_CMD_BIT = 7;
    localparam int WORD_RD_BIT = 6;
    localparam int WORD_CONT_BIT = 5;
    localparam int ADDR_W = 5;
    localparam logic [4:0] CMD_RESET = 5'h0f;

    // =========================================================
    // line assignment on the shared pins
    localparam int LINE_MOSI = 7;
    localparam int LINE_MISO = 6;
    localparam int LINE_RDFLAG = 5;
    localparam int LINE_SS = 4;
    localparam int LINE_DIRECT = 6;
    localparam int LINE_STROBE = 5;
    localparam int STRAP_ONE = 1;

    // =========================================================
    // counts and sizes
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [1:0] STRAP_TAKE = 2'h2;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 13;
    localparam logic [7:0] OE_ALL = 8'hff;
    localparam logic [7:0] OE_NONE = 8'h00;

endpackage

/* sim/port_monitor.sv */
// Purpose: port checker for the reader host command port
// Assumes: one SYS_CLK domain, NRST async active low
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module port_monitor (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [7:0] IO_OE,
    input wire logic IRQ,
    input wire logic IRQ_REQ,
    input wire logic [1:0] MODE,
    input wire logic MODE_VALID,
    input wire logic WR_VALID,
    input wire logic WR_READY,
    input wire logic [4:0] WR_ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic RD_STROBE,
    input wire logic CMD_STROBE,
    input wire logic [4:0] CMD_CODE,
    input wire logic RESET_CMD
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // =========================================
    // strobes: raised for one cycle, then dropped
    sequence s_drop(sig); ##1 !sig; endsequence
    property p_cmd_pulse; CMD_STROBE |-> s_drop(CMD_STROBE); endproperty
    property p_rd_pulse; RD_STROBE |-> s_drop(RD_STROBE); endproperty
    property p_reset_code; (CMD_STROBE || RESET_CMD) |-> CMD_STROBE &&
        RESET_CMD == (CMD_CODE == reader_port_pkg::CMD_RESET); endproperty
    // serial modes: lines seven and four must not be driven, line five must be
    property p_serial_in; MODE_VALID && MODE != reader_port_pkg::MODE_PARALLEL
        |-> !IO_OE[7] && !IO_OE[4]; endproperty
    property p_flag_oe; MODE_VALID && MODE != reader_port_pkg::MODE_PARALLEL
        |=> IO_OE[5]; endproperty
    property p_irq; $changed(IRQ_REQ) |=> IRQ == $past(IRQ_REQ); endproperty
    // straps are read once; a later strap change must not move the mode
    property p_mode_hold; MODE_VALID |=> MODE_VALID && $stable(MODE); endproperty
    property p_fifo_hold; WR_VALID && !WR_READY |=>
        WR_VALID && $stable({WR_ADDR, WR_DATA}); endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
    a_reset_code: assert property (p_reset_code) else $error("reset flag wrong");
    a_serial_in: assert property (p_serial_in) else $error("input line driven");
    a_flag_oe: assert property (p_flag_oe) else $error("line five not driven");
    a_irq: assert property (p_irq) else $error("irq not following");
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
    a_fifo_hold: assert property (p_fifo_hold) else $error("fifo head moved");
endmodule // port_monitor
bind reader_host_command_port port_monitor mon_u (.SYS_CLK, .NRST, .IO_OE, .IRQ, .IRQ_REQ,
    .MODE, .MODE_VALID, .WR_VALID, .WR_READY, .WR_ADDR, .WR_DATA, .RD_STROBE, .CMD_STROBE,
    .CMD_CODE, .RESET_CMD);

/* sim/host_master.sv */
// Purpose: host master model on the serial link with select
// Assumes: link clock stands still between frames
// Notes: eight system cycles per link bit, 400 ns
`timescale 1ns/1ps
module host_master (
    input wire logic sys_clk,
    input wire logic miso,
    input wire logic flag5,
    output logic sclk,
    output logic mosi,
    output logic ss_n,
    output logic flag_ok
);
    // idle levels before the first frame
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
        flag_ok = 1'b1;
    end
    // only this side ever opens a frame
    task automatic begin_frame;
        @(posedge sys_clk);
        ss_n <= 1'b0;
        flag_ok <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask
    // released data line shows the inverse, never a stale value
    task automatic end_frame;
        repeat (4) @(posedge sys_clk);
        ss_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge sys_clk);
    endtask
    // gap at byte start leaves room for the read fetch
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic rd = 1'b0);
        repeat (4) @(posedge sys_clk);
        for (int i = 7; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= tx[i];
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            rx[i] = miso;
            if (rd && flag5 !== 1'b1)
                flag_ok <= 1'b0;
        end
    endtask
endmodule // host_master

/* sim/testbench.sv */
// Purpose: self-checking bench of the reader host command port
// Assumes: straps 110 at first, serial link with select
// Notes: rows cover write, read and command words
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic irq_req = 1'b0;
    logic wr_ready = 1'b0;
    logic [2:0] strap = 3'b110;
    logic sclk, mosi, ss_n, flag_ok, irq, mode_valid, wr_valid, wr_ovf, rd_stb, cmd_stb;
    logic rst_cmd, rst_seen, dir_end;
    logic [3:0] drv = 4'h0; // line-seven flip, direct enable, data, strobe
    logic [7:0] io_out, io_oe, io_in, wr_data, rd_data, rx;
    logic [4:0] wr_addr, rd_addr, cmd_code, code_seen;
    logic [1:0] mode;
    int failures = 0;
    int tests_run = 0;
    int cmds = 0;
    logic [15:0] rows [5] = '{16'h03a5, 16'h1f5a, 16'h4500, 16'h8f00, 16'h8400};
    logic [4:0] straps [3] = '{5'b100_10, 5'b000_00, 5'b111_00};
    // =========================================
    // clock, wire levels, register side
    always #25 sys_clk = ~sys_clk;
    assign io_in = {mosi ^ drv[3], io_oe[6] & io_out[6], io_oe[5] & io_out[5], ss_n, 1'b0, strap};
    assign rd_data = {3'h5, rd_addr};
    always @(posedge sys_clk) begin
        if (cmd_stb === 1'b1) begin
            cmds++;
            code_seen = cmd_code;
            rst_seen = rst_cmd;
        end
    end
    host_master host_u (.sys_clk(sys_clk), .miso(io_in[6]), .flag5(io_in[5]), .sclk(sclk),
        .mosi(mosi), .ss_n(ss_n), .flag_ok(flag_ok));
    // direct-mode inputs from drv; drv[3] flips line seven for parallel stops
    reader_host_command_port dut_u (.SYS_CLK(sys_clk), .NRST(nrst), .DATA_CLK(sclk),
        .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .IRQ(irq), .IRQ_REQ(irq_req),
        .MODE(mode), .MODE_VALID(mode_valid), .WR_VALID(wr_valid), .WR_READY(wr_ready),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_OVERFLOW(wr_ovf), .RD_STROBE(rd_stb),
        .RD_ADDR(rd_addr), .RD_DATA(rd_data), .CMD_STROBE(cmd_stb), .CMD_CODE(cmd_code),
        .RESET_CMD(rst_cmd), .DIRECT_EN(drv[2]), .DIRECT_DATA(drv[1]), .DIRECT_STROBE(drv[0]),
        .DIRECT_END(dir_end));
    // =========================================
    // shared tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic await(ref logic sig);
        int n;
        for (n = 0; n < 300 && sig !== 1'b1; n++)
            @(posedge sys_clk);
        if (sig !== 1'b1) begin
            failures++;
            tally_and_finish;
        end
    endtask
    task automatic pop(input logic [4:0] a, input logic [7:0] d);
        await(wr_valid);
        check({3'h0, wr_addr}, {3'h0, a});
        check(wr_data, d);
        wr_ready <= 1'b1;
        @(posedge sys_clk);
        wr_ready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic run_row(input logic [7:0] w, input logic [7:0] d);
        int c;
        c = cmds;
        host_u.begin_frame();
        host_u.xfer(w, rx);
        if (!w[7])
            host_u.xfer(d, rx, w[6]);
        host_u.end_frame();
        if (w[7]) begin
            check(8'(cmds - c), 8'h01);
            check({3'h0, code_seen}, {3'h0, w[4:0]});
            check({7'h0, rst_seen}, {7'h0, w[4:0] == 5'h0f});
        end else if (w[6]) begin
            check(rx, {3'h5, w[4:0]});
            check({7'h0, flag_ok}, 8'h01);
        end else
            pop(w[4:0], d);
    endtask
    // =========================================
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        check(io_oe, 8'h00);
        nrst <= 1'b1;
        await(mode_valid);
        check({6'h0, mode}, 8'h01);
        $display("reset test done");
        foreach (rows[k])
            run_row(rows[k][15:8], rows[k][7:0]);
        $display("row tests done");
        // continuous write past a full buffer, address wraps at 5 bits
        host_u.begin_frame();
        host_u.xfer(8'h38, rx);
        for (int i = 0; i < 17; i++)
            host_u.xfer(8'(i), rx);
        host_u.end_frame();
        check({7'h0, wr_ovf}, 8'h01);
        for (int i = 0; i < 16; i++)
            pop(5'h18 + 5'(i), 8'(i));
        check({7'h0, wr_valid}, 8'h00);
        run_row(8'h5f, 8'h00);
        check({7'h0, wr_ovf}, 8'h00);
        $display("buffer test done");
        irq_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({7'h0, irq}, 8'h01);
        irq_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check({7'h0, irq}, 8'h00);
        $display("irq test done");
        foreach (straps[k]) begin
            nrst <= 1'b0;
            strap <= straps[k][4:2];
            repeat (2) @(posedge sys_clk);
            nrst <= 1'b1;
            await(mode_valid);
            check({6'h0, mode}, {6'h0, straps[k][1:0]});
        end
        $display("strap test done");
        drv <= {~mosi, 3'b110};
        repeat (4) @(posedge sys_clk);
        check(io_oe, 8'h60);
        check(io_out & 8'h60, 8'h40);
        drv[3] <= mosi;
        await(dir_end);
        check({7'h0, dir_end}, 8'h01);
        $display("direct test done");
        tally_and_finish;
    end
endmodule // testbench
